// >>> logic/fcm_host.sv
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "fcm_defs.svh"
module fcm_host
  import fcm_pkg::*;
#(
  parameter int ADDR_W = 19
)
(
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Flash pins
  output logic      [ADDR_W-1:0] flash_addr_o,
  output logic                   flash_ce_n_o,
  output logic                   flash_we_n_o,
  output logic                   flash_oe_n_o,
  input  wire logic [7:0]        flash_dq_i,
  output logic      [7:0]        flash_dq_o,
  output logic                   flash_dq_oe_o
);
  localparam logic [5:0] STROBE_CYC = 6'(`FCM_STROBE_CYC);

  // Command sequence table: up to six address/data writes.
  function automatic logic [ADDR_W+7:0] seq_entry(input logic [2:0] op, input logic [2:0] idx,
                                                  input logic [ADDR_W-1:0] ua,
                                                  input logic [7:0] ud);
    logic [ADDR_W+7:0] r;
    r = {`FCM_UNLOCK_ADDR1, `FCM_CMD_RESET};
    if (idx == 3'd0 || idx == 3'd3)
      r = {`FCM_UNLOCK_ADDR1, `FCM_UNLOCK_DATA1};
    else if (idx == 3'd1 || idx == 3'd4)
      r = {`FCM_UNLOCK_ADDR2, `FCM_UNLOCK_DATA2};
    case (op)
      `FCM_OP_RESET:
        r = {ua, `FCM_CMD_RESET};
      `FCM_OP_AUTOSEL:
        if (idx == 3'd2) r = {`FCM_UNLOCK_ADDR1, `FCM_CMD_AUTOSEL};
      `FCM_OP_PROGRAM:
        if (idx == 3'd2) r = {`FCM_UNLOCK_ADDR1, `FCM_CMD_PROGRAM};
        else if (idx == 3'd3) r = {ua, ud};
      `FCM_OP_CHIP_ERASE:
        if (idx == 3'd2) r = {`FCM_UNLOCK_ADDR1, `FCM_CMD_ERASE_SET};
        else if (idx == 3'd5) r = {`FCM_UNLOCK_ADDR1, `FCM_CMD_CHIP_ERASE};
      default: r = {ua, ud};
    endcase
    return r;
  endfunction

  fcm_state_t        state, next_state;
  logic [2:0]        op, next_op;
  logic [2:0]        idx, next_idx;
  logic [5:0]        tcnt, next_tcnt;
  logic [31:0]       pcnt, next_pcnt;
  logic [ADDR_W-1:0] uaddr, next_uaddr;
  logic [7:0]        udata, next_udata;
  logic [7:0]        rdata, next_rdata;
  logic [7:0]        prev, next_prev;
  logic              busy, next_busy;
  logic              tl_err, next_tl_err;
  logic              to_err, next_to_err;
  logic              idmode, next_idmode;
  logic              polling, next_polling;
  logic              ack, next_ack;
  logic [31:0]       next_wb_dat;
  logic [ADDR_W+7:0] ent;
  logic [2:0]        last_idx;
  logic              wr_hit;

  assign wr_hit = wb_cyc_i && wb_stb_i && !ack && wb_we_i && wb_sel_i[0];
  assign ent    = seq_entry(op, idx, uaddr, udata);
  always_comb
  begin
    case (op)
      `FCM_OP_RESET:      last_idx = 3'd0;
      `FCM_OP_AUTOSEL:    last_idx = 3'd2;
      `FCM_OP_PROGRAM:    last_idx = 3'd3;
      `FCM_OP_CHIP_ERASE: last_idx = 3'd5;
      default:            last_idx = 3'd0;
    endcase
  end

  always_comb
  begin
    next_state  = state;
    next_op     = op;
    next_idx    = idx;
    next_tcnt   = tcnt;
    next_pcnt   = pcnt;
    next_uaddr  = uaddr;
    next_udata  = udata;
    next_rdata  = rdata;
    next_prev   = prev;
    next_busy   = busy;
    next_tl_err = tl_err;
    next_to_err = to_err;
    next_idmode = idmode;
    next_polling = polling;
    next_ack    = 1'b0;
    next_wb_dat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !ack)
    begin
      next_ack = 1'b1;
      case (wb_adr_i)
        `FCM_REG_ADDR:   next_wb_dat = 32'(uaddr);
        `FCM_REG_DATA:   next_wb_dat = {24'h000000, rdata};
        `FCM_REG_STATUS: next_wb_dat = {28'h0000000, idmode, to_err, tl_err, busy};
        default:         next_wb_dat = 32'h0000_0000;
      endcase
    end
    if (wr_hit && wb_adr_i == `FCM_REG_ADDR && !busy)
      next_uaddr = wb_dat_i[ADDR_W-1:0];
    if (wr_hit && wb_adr_i == `FCM_REG_DATA && !busy)
      next_udata = wb_dat_i[7:0];
    case (state)
      FCM_IDLE:
        if (wr_hit && wb_adr_i == `FCM_REG_CTRL && !busy)
        begin
          next_op    = wb_dat_i[2:0];
          next_idx   = 3'd0;
          next_busy  = 1'b1;
          next_tcnt  = STROBE_CYC;
          next_state = FCM_SETUP;
          if (wb_dat_i[2:0] == `FCM_OP_RESET)
          begin
            next_tl_err = 1'b0;
            next_to_err = 1'b0;
            next_idmode = 1'b0;
          end
        end
      FCM_SETUP:
        next_state = (op == `FCM_OP_READ || op == `FCM_OP_IDREAD) ? FCM_READ : FCM_WRITE;
      FCM_WRITE:
        if (tcnt == 6'd1)
        begin
          next_tcnt  = STROBE_CYC;
          next_state = FCM_GAP;
        end
        else
          next_tcnt = tcnt - 6'd1;
      FCM_READ:
        if (tcnt == 6'd1)
        begin
          next_rdata = flash_dq_i;
          next_tcnt  = STROBE_CYC;
          next_state = FCM_GAP;
        end
        else
          next_tcnt = tcnt - 6'd1;
      FCM_GAP:
        if (tcnt == 6'd1)
        begin
          if ((op == `FCM_OP_PROGRAM || op == `FCM_OP_CHIP_ERASE) && idx == last_idx)
          begin
            next_op    = `FCM_OP_READ;
            next_pcnt  = 32'h0000_0000;
            next_prev  = rdata;
            next_polling = 1'b1;
            next_state = FCM_POLL;
          end
          else if (polling)
            next_state = FCM_POLL;
          else if (idx == last_idx || op == `FCM_OP_READ || op == `FCM_OP_IDREAD)
          begin
            if (op == `FCM_OP_AUTOSEL)
              next_idmode = 1'b1;
            next_busy  = 1'b0;
            next_state = FCM_IDLE;
          end
          else
          begin
            next_idx   = idx + 3'd1;
            next_tcnt  = STROBE_CYC;
            next_state = FCM_SETUP;
          end
        end
        else
          next_tcnt = tcnt - 6'd1;
      FCM_POLL:
      begin
        // Two reads in a row that do not toggle mean the algorithm is done.
        next_prev  = rdata;
        next_pcnt  = pcnt + 32'h0000_0001;
        next_tcnt  = STROBE_CYC;
        if (rdata[`FCM_BIT_TOGGLE] == prev[`FCM_BIT_TOGGLE] && pcnt > 32'h0000_0001)
        begin
          next_busy  = 1'b0;
          next_polling = 1'b0;
          next_state = FCM_IDLE;
        end
        // The time limit counts only when two toggling status reads both show it,
        // so array data that happens to have that bit set is not taken for a failure.
        else if (rdata[`FCM_BIT_TIME_LIMIT] && prev[`FCM_BIT_TIME_LIMIT] && pcnt > 32'h0000_0001)
        begin
          next_tl_err = 1'b1;
          next_busy   = 1'b0;
          next_polling = 1'b0;
          next_state  = FCM_IDLE;
        end
        else if (pcnt == `FCM_POLL_MAX)
        begin
          next_to_err = 1'b1;
          next_busy   = 1'b0;
          next_polling = 1'b0;
          next_state  = FCM_IDLE;
        end
        else
          next_state = FCM_READ;
      end
      default: next_state = FCM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state    <= FCM_IDLE;
      op       <= `FCM_OP_READ;
      idx      <= 3'd0;
      tcnt     <= 6'd0;
      pcnt     <= 32'h0000_0000;
      uaddr    <= '0;
      udata    <= 8'h00;
      rdata    <= 8'h00;
      prev     <= 8'h00;
      busy     <= 1'b0;
      tl_err   <= 1'b0;
      to_err   <= 1'b0;
      idmode   <= 1'b0;
      polling  <= 1'b0;
      ack      <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      state    <= next_state;
      op       <= next_op;
      idx      <= next_idx;
      tcnt     <= next_tcnt;
      pcnt     <= next_pcnt;
      uaddr    <= next_uaddr;
      udata    <= next_udata;
      rdata    <= next_rdata;
      prev     <= next_prev;
      busy     <= next_busy;
      tl_err   <= next_tl_err;
      to_err   <= next_to_err;
      idmode   <= next_idmode;
      polling  <= next_polling;
      ack      <= next_ack;
      wb_dat_o <= next_wb_dat;
    end
  end

  assign wb_ack_o = ack;

  // Chip enable and write enable fall and rise together, so address is taken at
  // the shared falling edge and data at the shared rising edge.
  logic [ADDR_W-1:0] next_faddr;
  logic [7:0]        next_fdq;
  logic              next_ce_n, next_we_n, next_oe_n, next_dq_oe;
  always_comb
  begin
    next_faddr = (op == `FCM_OP_READ || op == `FCM_OP_IDREAD) ? uaddr : ent[ADDR_W+7:8];
    next_fdq   = ent[7:0];
    next_ce_n  = !(state == FCM_WRITE || state == FCM_READ);
    next_we_n  = !(state == FCM_WRITE);
    next_oe_n  = !(state == FCM_READ);
    // Data is driven one cycle past the write strobe, so that it still stands
    // when the device latches it at the rising edge of the strobes.
    next_dq_oe = state == FCM_WRITE || state == FCM_SETUP
                 || (state == FCM_GAP && tcnt == STROBE_CYC);
    if (op == `FCM_OP_READ || op == `FCM_OP_IDREAD)
      next_dq_oe = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flash_addr_o  <= '0;
      flash_dq_o    <= 8'h00;
      flash_ce_n_o  <= 1'b1;
      flash_we_n_o  <= 1'b1;
      flash_oe_n_o  <= 1'b1;
      flash_dq_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      flash_addr_o  <= next_faddr;
      flash_dq_o    <= next_fdq;
      flash_ce_n_o  <= next_ce_n;
      flash_we_n_o  <= next_we_n;
      flash_oe_n_o  <= next_oe_n;
      flash_dq_oe_o <= next_dq_oe;
    end
  end
endmodule // fcm_host
`default_nettype wire

// >>> include/fcm_defs.svh
`ifndef FCM_DEFS_SVH
`define FCM_DEFS_SVH
// Behaviour
// - Host writes reset to leave identification mode.
// - Host resets device after time limit flag; the code only sets tl_err and goes idle, software must issue FCM_OP_RESET.
// - Program takes four writes, last starts algorithm.
// - Chip erase takes six writes.

// Unlock addresses and command bytes.
`define FCM_UNLOCK_ADDR1   19'h00555
`define FCM_UNLOCK_ADDR2   19'h002AA
`define FCM_UNLOCK_DATA1   8'hAA
`define FCM_UNLOCK_DATA2   8'h55
`define FCM_CMD_RESET      8'hF0
`define FCM_CMD_AUTOSEL    8'h90
`define FCM_CMD_PROGRAM    8'hA0
`define FCM_CMD_ERASE_SET  8'h80
`define FCM_CMD_CHIP_ERASE 8'h10
`define FCM_ID_MAKER_LOW   8'h00
`define FCM_ID_DEVICE_LOW  8'h01
`define FCM_ID_PROTECT_LOW 8'h02
`define FCM_ID_CONT_LOW    8'h11

// Status bit positions in a read byte.
`define FCM_BIT_POLL       7
`define FCM_BIT_TOGGLE     6
`define FCM_BIT_TIME_LIMIT 5

// Wishbone register offsets (byte addresses).
`define FCM_REG_CTRL       4'h0
`define FCM_REG_ADDR       4'h4
`define FCM_REG_DATA       4'h8
`define FCM_REG_STATUS     4'hC

// Operation codes written to the control register.
`define FCM_OP_READ        3'h0
`define FCM_OP_RESET       3'h1
`define FCM_OP_AUTOSEL     3'h2
`define FCM_OP_PROGRAM     3'h3
`define FCM_OP_CHIP_ERASE  3'h4
`define FCM_OP_IDREAD      3'h5

// Strobe timing in ns, converted to 4 ns cycles rounding up.
`define FCM_CLK_NS         4
`define FCM_STROBE_NS      60
`define FCM_STROBE_CYC     ((`FCM_STROBE_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`define FCM_POLL_MAX       32'h0100_0000
`endif

// >>> include/fcm_pkg.sv
package fcm_pkg;
  typedef enum logic [5:0] {
    FCM_IDLE  = 6'b000001,
    FCM_SETUP = 6'b000010,
    FCM_WRITE = 6'b000100,
    FCM_READ  = 6'b001000,
    FCM_GAP   = 6'b010000,
    FCM_POLL  = 6'b100000
  } fcm_state_t;
endpackage

// >>> verif/fcm_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fcm_host_chk #(
  parameter int ADDR_W = 19
)
(
  // Clock and bus
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_ack_o,
  // Flash pins
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic              flash_ce_n_o,
  input wire logic              flash_we_n_o,
  input wire logic              flash_oe_n_o,
  input wire logic [7:0]        flash_dq_o,
  input wire logic              flash_dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_low15;
    !flash_we_n_o[*8] ##1 !flash_we_n_o[*7];
  endsequence
  chk_reset_idle: assert property ($fell(rst_i) |-> flash_ce_n_o && flash_we_n_o &&
    !flash_dq_oe_o && !wb_ack_o) else $error("strobes active after reset");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
  // The write pulse must be long enough for the device to latch data.
  chk_we_width: assert property ($fell(flash_we_n_o) |-> (!flash_ce_n_o throughout s_low15)
    ##1 flash_we_n_o) else $error("write pulse width wrong");
  chk_we_gap: assert property ($rose(flash_we_n_o) |-> flash_we_n_o[*8])
    else $error("write gap too short");
  chk_write_drive: assert property (!flash_we_n_o |-> flash_oe_n_o && flash_dq_oe_o)
    else $error("write without data drive");
  chk_read_float: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && !flash_ce_n_o)
    else $error("read while driving data");
  chk_wr_stable: assert property (!flash_we_n_o && !$past(flash_we_n_o) |->
    $stable(flash_addr_o) && $stable(flash_dq_o)) else $error("write operands moved");
endmodule // fcm_host_chk
bind fcm_host fcm_host_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
  .flash_addr_o(flash_addr_o), .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o));
`default_nettype wire

// >>> verif/fcm_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fcm_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'hC1, // Arbitrary value.
  parameter logic [7:0] DEV_CODE   = 8'hC3, // Arbitrary value.
  parameter logic [7:0] CONT_CODE  = 8'hC5, // Arbitrary value.
  parameter logic [7:0] PROT_MAP   = 8'h08,
  parameter int         BUSY_NS    = 3000
)
(
  // Pins
  input  wire logic [18:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [7:0]  dq_i,
  output logic      [7:0]  dq_o
);
  logic [7:0]  mem [int];
  logic [18:0] la;
  logic [7:0]  pd;
  logic [7:0]  last = 8'h00;
  int          step = 0;
  bit          idm  = 0;
  bit          busy = 0;
  bit          tog  = 0;
  wire logic   wr = !we_n_i && !ce_n_i && oe_n_i;
  wire logic   rd = !oe_n_i && !ce_n_i;
  function automatic logic [7:0] val(input logic [18:0] a);
    if (busy) return {~pd[7], tog, 3'b000, tog, 2'b00};
    if (idm) case (a[7:0])
      8'h00: return MAKER_CODE;
      8'h01: return DEV_CODE;
      8'h11: return CONT_CODE;
      8'h02: return {7'h00, PROT_MAP[a[18:16]]};
      default: return 8'h00;
    endcase
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // The embedded run blocks this process, so writes meanwhile are lost.
  task automatic run(input bit prog);
    busy = 1;
    pd = prog ? dq_i : 8'hFF;
    #(BUSY_NS);
    if (prog) mem[la] = (mem.exists(la) ? mem[la] : 8'hFF) & pd;
    else mem.delete();
    busy = 0;
  endtask
  always @(posedge wr) la = addr_i;
  always @(negedge wr)
  begin
    if (busy) ;
    else if (dq_i == 8'hF0) begin step = 0; idm = 0; end
    else if (step == 6) begin step = 0; run(1'b1); end
    else if (step == 5 && la[10:0] == 11'h555 && dq_i == 8'h10) begin step = 0; run(1'b0); end
    else if (step == 2 && la[10:0] == 11'h555 && dq_i inside {8'h90, 8'hA0, 8'h80})
    begin
      idm = idm || dq_i == 8'h90;
      step = dq_i == 8'hA0 ? 6 : dq_i == 8'h80 ? 3 : 0;
    end
    else if ((step % 3 == 0 && la[10:0] == 11'h555 && dq_i == 8'hAA) ||
      (step % 3 == 1 && la[10:0] == 11'h2AA && dq_i == 8'h55)) step++;
    else step = 0;
  end
  always @(negedge rd)
  begin
    last = val(addr_i);
    if (busy) tog = !tog;
  end
  // No pull-up on the data lines, so a released bus shows no stale byte.
  assign dq_o = rd ? val(addr_i) : ~last;
endmodule // fcm_flash_model
`default_nettype wire

// >>> verif/fcm_host_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcm_defs.svh"
module fcm_host_test;
  localparam logic [7:0] MAKER = 8'h4D; // Arbitrary value.
  localparam logic [7:0] DEV   = 8'h62; // Arbitrary value.
  localparam logic [7:0] CONT  = 8'h7A; // Arbitrary value.
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        wb_cyc = 0;
  logic        wb_stb = 0;
  logic        wb_we = 0;
  logic        ce = 1'b1;
  logic [3:0]  wb_sel = 4'h0;
  logic        wb_ack;
  logic [3:0]  wb_adr = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic [31:0] rv;
  logic [18:0] f_addr;
  logic        f_ce_n;
  logic        f_we_n;
  logic        f_oe_n;
  logic        f_oe;
  logic [7:0]  f_dq_o;
  logic [7:0]  m_dq;
  wire logic [7:0] f_dq = f_oe ? f_dq_o : m_dq;
  int          n_errors = 0;
  int          n_tests = 0;
  fcm_host #(.ADDR_W(19)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .flash_addr_o(f_addr), .flash_ce_n_o(f_ce_n),
    .flash_we_n_o(f_we_n), .flash_oe_n_o(f_oe_n), .flash_dq_i(f_dq), .flash_dq_o(f_dq_o),
    .flash_dq_oe_o(f_oe));
  fcm_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV), .CONT_CODE(CONT), .PROT_MAP(8'h08))
    FLASH (.addr_i(f_addr), .ce_n_i(f_ce_n), .we_n_i(f_we_n), .oe_n_i(f_oe_n), .dq_i(f_dq),
    .dq_o(m_dq));
  initial forever #2 clk_i = ~clk_i;
  task automatic end_of_test;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_wdat <= d;
    wb_sel <= 4'hF;
    do begin @(posedge clk_i); i++; end while (wb_ack !== 1'b1 && i < 100);
    rv = wb_rdat;
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
    if (i >= 100) begin n_errors++; end_of_test(); end
  endtask
  // Busy is polled over the bus, as software would, rather than waited out.
  task automatic op(input logic [2:0] c, input logic [18:0] a, input logic [7:0] d);
    int i;
    i = 0;
    wb(1'b1, `FCM_REG_ADDR, {13'h0, a});
    wb(1'b1, `FCM_REG_DATA, {24'h0, d});
    wb(1'b1, `FCM_REG_CTRL, {29'h0, c});
    do begin wb(1'b0, `FCM_REG_STATUS, 32'h0); i++; end while (rv[0] !== 1'b0 && i < 5000);
    if (i >= 5000) begin n_errors++; end_of_test(); end
  endtask
  task automatic rdb(input logic [2:0] c, input logic [18:0] a, input logic [7:0] e);
    op(c, a, 8'h00);
    wb(1'b0, `FCM_REG_DATA, 32'h0);
    chk(rv, {24'h0, e});
  endtask
  task automatic t_powerup;
    rdb(`FCM_OP_READ, 19'h12345, 8'hFF);
    wb(1'b0, 4'h2, 32'h0);
    chk(rv, 32'h0);
  endtask
  // A request raised while the clock enable is low must wait until it returns.
  task automatic t_freeze;
    @(posedge clk_i);
    ce <= 1'b0;
    fork
      wb(1'b0, `FCM_REG_STATUS, 32'h0);
      begin
        repeat (6) @(posedge clk_i);
        chk({31'h0, wb_ack}, 32'h0);
        ce <= 1'b1;
      end
    join
    chk(rv, 32'h0);
  endtask
  task automatic t_program;
    op(`FCM_OP_PROGRAM, 19'h12345, 8'hA5);
    chk(rv, 32'h0);
    rdb(`FCM_OP_READ, 19'h12345, 8'hA5);
    op(`FCM_OP_PROGRAM, 19'h70001, 8'h3C);
    rdb(`FCM_OP_READ, 19'h70001, 8'h3C);
    op(`FCM_OP_PROGRAM, 19'h12345, 8'h5A);
    rdb(`FCM_OP_READ, 19'h12345, 8'h00);
  endtask
  task automatic t_ident;
    op(`FCM_OP_AUTOSEL, 19'h0, 8'h00);
    chk(rv & 32'h8, 32'h8);
    rdb(`FCM_OP_IDREAD, 19'h00100, MAKER);
    rdb(`FCM_OP_IDREAD, 19'h00201, DEV);
    rdb(`FCM_OP_IDREAD, 19'h00311, CONT);
    rdb(`FCM_OP_IDREAD, 19'h30002, 8'h01);
    rdb(`FCM_OP_IDREAD, 19'h40002, 8'h00);
    rdb(`FCM_OP_IDREAD, 19'h00100, MAKER);
    op(`FCM_OP_RESET, 19'h6ABCD, 8'h00);
    chk(rv & 32'h8, 32'h0);
    rdb(`FCM_OP_READ, 19'h70001, 8'h3C);
  endtask
  task automatic t_erase;
    op(`FCM_OP_CHIP_ERASE, 19'h0, 8'h00);
    chk(rv, 32'h0);
    rdb(`FCM_OP_READ, 19'h70001, 8'hFF);
    rdb(`FCM_OP_READ, 19'h12345, 8'hFF);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_powerup();
    t_freeze();
    t_program();
    t_ident();
    t_erase();
    end_of_test();
  end
endmodule // fcm_host_test
`default_nettype wire
